// [sarpm_map.vh]
`ifndef SARPM_MAP_VH
`define SARPM_MAP_VH
// ***************************************
// result word and timing
// ***************************************
`define SARPM_RES_BITS        15
`define SARPM_CONV_TIME_NS    500
`define SARPM_CLK_PERIOD_NS   50
// ***************************************
// power state codes, one-hot
// ***************************************
`define SARPM_ST_OPER         3'h1
`define SARPM_ST_NAP          3'h2
`define SARPM_ST_SLEEP        3'h4
// ***************************************
// idle pulse counts
// ***************************************
`define SARPM_CNT_NAP         3'h2
`define SARPM_CNT_SLEEP       3'h4
`define SARPM_CNT_WAKE        3'h5
`define SARPM_CNT_ZERO        3'h0
// ***************************************
// pin idle levels
// ***************************************
`define SARPM_CNV_IDLE        1'b1
`endif

// [sarpm_sync.v]
`timescale 1ns/10ps
`default_nettype none
// ***************************************
// three-stage synchroniser with edge detect
// ***************************************
module sarpm_sync
#(
   parameter [0:0] RST_LEVEL = 1'b0
)
(
   input  wire clk_in,
   input  wire rst_in,
   input  wire d_in,
   output wire level_out,
   output wire rise_out,
   output wire fall_out
);
   reg s1;
   reg s2;
   reg s3;
   reg lvl;
   // stage one feeds only stage two; a change counts when two and three agree
   always @(posedge clk_in)
   begin
      // stages reset to the pin's idle level so no false edge follows reset
      if (rst_in)
      begin
         s1  <= RST_LEVEL;
         s2  <= RST_LEVEL;
         s3  <= RST_LEVEL;
         lvl <= RST_LEVEL;
      end
      else
      begin
         s1 <= d_in;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3)
            lvl <= s3;
      end
   end
   // edges are seen when the agreed level first differs from the held one
   assign level_out = lvl;
   assign rise_out  = (s2 == s3) & s3 & ~lvl;
   assign fall_out  = (s2 == s3) & ~s3 & lvl;
endmodule // sarpm_sync
`default_nettype wire

// [sarpm_top.v]
`timescale 1ns/10ps
`default_nettype none
`include "sarpm_map.vh"
// Operation
// - falling edge of conversion_start_n starts an internally timed conversion
// - each serial clock falling edge after the first shifts out the next result bit, msb first
// - nap saves power without wake delay; sleep saves more, needs power-up delay
// - two start pulses with clock idle enter nap on second rising edge
// - nap ends on serial clock rising edge or further start pulses
// - two more idle pulses while napping move the device into sleep
// - in cmos mode a serial clock rising edge wakes from sleep
// - in lvds mode a fifth idle start pulse wakes from sleep
// - after fifth-pulse wake, clock activity prevents nap and sleep
// - fifth-pulse wake also works in cmos mode
// - with no clock edges, pulses cycle operational, nap, sleep forever
// - static select input chooses cmos or lvds signalling
// - cmos uses positive data and clock lines; complements unused
// - lvds uses differential data output and clock input pairs
module sarpm_top
#(
   parameter RES_BITS = `SARPM_RES_BITS
)
(
   input  wire                CLK_SYS_IN,
   input  wire                RST_IN,
   input  wire                CONVERSION_START_N_IN,
   input  wire                SCK_POS_IN,
   input  wire                SCK_NEG_IN,
   input  wire                LVDS_SELECT_IN,
   input  wire [RES_BITS-1:0] RESULT_IN,
   output reg                 SERIAL_OUT_POS_OUT,
   output reg                 SERIAL_OUT_NEG_OUT,
   output reg                 SERIAL_OUT_NEG_OE_OUT,
   output reg                 CONVERTING_OUT,
   output reg                 NAP_OUT,
   output reg                 SLEEP_OUT
);
   // ***************************************
   // derived timing
   // ***************************************
   localparam integer CONV_CYCLES_I = `SARPM_CONV_TIME_NS / `SARPM_CLK_PERIOD_NS;
   localparam [7:0]   CONV_CYCLES   = CONV_CYCLES_I[7:0];
   localparam [2:0]   ST_OPER       = `SARPM_ST_OPER;
   localparam [2:0]   ST_NAP        = `SARPM_ST_NAP;
   localparam [2:0]   ST_SLEEP      = `SARPM_ST_SLEEP;

   // ***************************************
   // pin synchronisers
   // ***************************************
   wire cnv_rise;
   wire cnv_fall;
   wire sck_rise;
   wire sck_fall;
   wire sck_pin;
   reg  lvds_mode;

   // lvds pair is resolved to a single level before sampling
   assign sck_pin = lvds_mode ? (SCK_POS_IN & ~SCK_NEG_IN) : SCK_POS_IN;

   // start pin idles high; resetting its stages low would count a false pulse
   sarpm_sync
   #(
      .RST_LEVEL (`SARPM_CNV_IDLE)
   )
   u_cnv_sync
   (
      .clk_in    (CLK_SYS_IN),
      .rst_in    (RST_IN),
      .d_in      (CONVERSION_START_N_IN),
      .level_out (),
      .rise_out  (cnv_rise),
      .fall_out  (cnv_fall)
   );

   sarpm_sync u_sck_sync
   (
      .clk_in    (CLK_SYS_IN),
      .rst_in    (RST_IN),
      .d_in      (sck_pin),
      .level_out (),
      .rise_out  (sck_rise),
      .fall_out  (sck_fall)
   );

   // ***************************************
   // interface mode select
   // ***************************************
   // select is static, so it is simply retimed; a mid-run change is not supported
   reg sel_s1;
   reg sel_s2;
   always @(posedge CLK_SYS_IN)
   begin
      if (RST_IN)
      begin
         sel_s1    <= 1'b0;
         sel_s2    <= 1'b0;
         lvds_mode <= 1'b0;
      end
      else
      begin
         sel_s1    <= LVDS_SELECT_IN;
         sel_s2    <= sel_s1;
         lvds_mode <= sel_s2;
      end
   end

   // ***************************************
   // conversion timing and shift register
   // ***************************************
   reg [7:0]          conv_cnt;
   reg [RES_BITS-1:0] shreg;
   reg                first_bit;

   // conversion is timed here with no serial clock needed
   always @(posedge CLK_SYS_IN)
   begin
      if (RST_IN)
      begin
         conv_cnt       <= 8'h00;
         CONVERTING_OUT <= 1'b0;
         shreg          <= {RES_BITS{1'b0}};
         first_bit      <= 1'b0;
      end
      else if (cnv_fall && !CONVERTING_OUT)
      begin
         conv_cnt       <= CONV_CYCLES;
         CONVERTING_OUT <= 1'b1;
      end
      else if (CONVERTING_OUT)
      begin
         if (conv_cnt == 8'h01)
         begin
            CONVERTING_OUT <= 1'b0;
            shreg          <= RESULT_IN; // result latched at end of conversion
            first_bit      <= 1'b1;
         end
         conv_cnt <= conv_cnt - 8'h01;
      end
      else if (sck_fall)
      begin
         // the msb is shown on the first fall, later falls shift
         if (first_bit)
            first_bit <= 1'b0;
         else
            shreg <= {shreg[RES_BITS-2:0], 1'b0};
      end
   end

   // ***************************************
   // serial data drivers
   // ***************************************
   // complement line is only driven in lvds mode; in cmos it floats
   always @(posedge CLK_SYS_IN)
   begin
      if (RST_IN)
      begin
         SERIAL_OUT_POS_OUT    <= 1'b0;
         SERIAL_OUT_NEG_OUT    <= 1'b0;
         SERIAL_OUT_NEG_OE_OUT <= 1'b0;
      end
      else
      begin
         SERIAL_OUT_POS_OUT    <= shreg[RES_BITS-1];
         SERIAL_OUT_NEG_OUT    <= ~shreg[RES_BITS-1];
         SERIAL_OUT_NEG_OE_OUT <= lvds_mode;
      end
   end

   // ***************************************
   // power state machine
   // ***************************************
   reg [2:0] state;
   reg [2:0] next_state;
   reg [2:0] idle_cnt;
   reg [2:0] next_idle_cnt;

   // pulses are counted on the start rising edge, only while the clock is idle
   always @*
   begin
      next_state    = state;
      next_idle_cnt = idle_cnt;
      if (sck_rise)
      begin
         next_idle_cnt = `SARPM_CNT_ZERO;
         if (state == ST_NAP)
            next_state = ST_OPER;
         else if (state == ST_SLEEP && !lvds_mode)
            next_state = ST_OPER;
      end
      else if (cnv_rise)
      begin
         next_idle_cnt = idle_cnt + 3'h1;
         case (state)
            ST_OPER:
               if (next_idle_cnt >= `SARPM_CNT_NAP)
                  next_state = ST_NAP;
            ST_NAP:
               if (next_idle_cnt >= `SARPM_CNT_SLEEP)
                  next_state = ST_SLEEP;
            ST_SLEEP:
               if (next_idle_cnt >= `SARPM_CNT_WAKE)
               begin
                  next_state    = ST_OPER;
                  next_idle_cnt = `SARPM_CNT_ZERO; // cycle restarts
               end
            default:
               next_state = ST_OPER;
         endcase
      end
   end

   // nap and sleep are reported as levels for the analog power controls
   always @(posedge CLK_SYS_IN)
   begin
      if (RST_IN)
      begin
         state     <= ST_OPER;
         idle_cnt  <= `SARPM_CNT_ZERO;
         NAP_OUT   <= 1'b0;
         SLEEP_OUT <= 1'b0;
      end
      else
      begin
         state     <= next_state;
         idle_cnt  <= next_idle_cnt;
         NAP_OUT   <= (next_state == ST_NAP);
         SLEEP_OUT <= (next_state == ST_SLEEP);
      end
   end
endmodule // sarpm_top
`default_nettype wire

// [sarpm_sva.sv]
`timescale 1ns/10ps
`default_nettype none
// ****
// power state and readout checks
// ****
module sarpm_sva
(
   input wire logic CLK_SYS_IN,
   input wire logic RST_IN,
   input wire logic SCK_POS_IN,
   input wire logic SCK_NEG_IN,
   input wire logic LVDS_SELECT_IN,
   input wire logic SERIAL_OUT_POS_OUT,
   input wire logic SERIAL_OUT_NEG_OUT,
   input wire logic SERIAL_OUT_NEG_OE_OUT,
   input wire logic CONVERTING_OUT,
   input wire logic NAP_OUT,
   input wire logic SLEEP_OUT
);
   // clock as the block decodes it in either mode
   wire logic sck = SCK_POS_IN & ~(LVDS_SELECT_IN & SCK_NEG_IN);
   default clocking @(posedge CLK_SYS_IN); endclocking
   default disable iff (RST_IN);
   // window of eight cycles long enough to cover the pin synchronisers
   sequence conv_run;
      CONVERTING_OUT[*8] ##1 CONVERTING_OUT[*2] ##1 !CONVERTING_OUT;
   endsequence
   sequence sck_quiet;
      ($stable(SCK_POS_IN) && !CONVERTING_OUT)[*8];
   endsequence
   conv_length_a: assert property ($rose(CONVERTING_OUT) |-> conv_run)
      else $error("conversion length");
   data_hold_a: assert property (sck_quiet |-> $stable(SERIAL_OUT_POS_OUT))
      else $error("data moved without clock");
   state_excl_a: assert property (!(NAP_OUT && SLEEP_OUT))
      else $error("nap and sleep together");
   nap_wake_a: assert property (NAP_OUT && $rose(sck) |-> ##[1:7] !NAP_OUT)
      else $error("nap kept after clock");
   sleep_entry_a: assert property ($rose(SLEEP_OUT) |-> $past(NAP_OUT))
      else $error("sleep not from nap");
   cmos_wake_a: assert property (SLEEP_OUT && !LVDS_SELECT_IN && $rose(sck) |->
      ##[1:7] !SLEEP_OUT)
      else $error("sleep kept after clock");
   neg_drive_a: assert property ((!RST_IN && $stable(LVDS_SELECT_IN))[*5] |->
      SERIAL_OUT_NEG_OE_OUT == LVDS_SELECT_IN)
      else $error("complement drive mode");
   neg_data_a: assert property (SERIAL_OUT_NEG_OE_OUT |->
      SERIAL_OUT_NEG_OUT != SERIAL_OUT_POS_OUT)
      else $error("complement data");
endmodule // sarpm_sva
bind sarpm_top sarpm_sva u_sarpm_sva (.CLK_SYS_IN(CLK_SYS_IN), .RST_IN(RST_IN),
   .SCK_POS_IN(SCK_POS_IN), .SCK_NEG_IN(SCK_NEG_IN), .LVDS_SELECT_IN(LVDS_SELECT_IN),
   .SERIAL_OUT_POS_OUT(SERIAL_OUT_POS_OUT), .SERIAL_OUT_NEG_OUT(SERIAL_OUT_NEG_OUT),
   .SERIAL_OUT_NEG_OE_OUT(SERIAL_OUT_NEG_OE_OUT), .CONVERTING_OUT(CONVERTING_OUT),
   .NAP_OUT(NAP_OUT), .SLEEP_OUT(SLEEP_OUT));
`default_nettype wire

// [sarpm_host.sv]
`timescale 1ns/10ps
`default_nettype none
module sarpm_host
(
   input  wire logic lvds_in,
   input  wire logic sdo_in,
   output var  logic cnv_n_out,
   output var  logic sck_p_out,
   output wire logic sck_n_out
);
   // unused complement sits at its pull-down level in cmos
   assign sck_n_out = lvds_in & ~sck_p_out;
   initial
   begin
      cnv_n_out = 1'b1;
      sck_p_out = 1'b0;
   end
   // pulse kept four clocks wide so the synchroniser always sees it
   task automatic pulse;
      cnv_n_out = 1'b0;
      #200 cnv_n_out = 1'b1;
      #300;
   endtask
   // slowed clock rate; the block samples it with its own clock
   task automatic clock_once;
      sck_p_out = 1'b1;
      #200 sck_p_out = 1'b0;
      #200;
   endtask
   // bit taken mid high phase: the block shows a new bit about five clocks after a fall
   task automatic clock_sample(output logic b);
      sck_p_out = 1'b1;
      #100 b = sdo_in;
      #100 sck_p_out = 1'b0;
      #200;
   endtask
   // every conversion is read out so pulses never count as power-down
   task automatic read_word(output logic [14:0] w);
      pulse();
      #500 clock_once();
      for (int i = 14; i >= 0; i--)
      begin
         clock_sample(w[i]);
      end
   endtask
endmodule // sarpm_host
`default_nettype wire

// [test_sarpm_top.sv]
`timescale 1ns/10ps
`default_nettype none
module test_sarpm_top;
   logic clk, rst, lvds, cnv_n, sck_p, sck_n, sdo_p, sdo_n, sdo_oe, conv, nap, sleep;
   logic [14:0] result;
   int bad_count = 0;
   int checks_done = 0;
   localparam int WAKE_NS = 2000; // shortened settle wait after sleep
   sarpm_top u_sarpm_top (.CLK_SYS_IN(clk), .RST_IN(rst), .CONVERSION_START_N_IN(cnv_n),
      .SCK_POS_IN(sck_p), .SCK_NEG_IN(sck_n), .LVDS_SELECT_IN(lvds), .RESULT_IN(result),
      .SERIAL_OUT_POS_OUT(sdo_p), .SERIAL_OUT_NEG_OUT(sdo_n), .SERIAL_OUT_NEG_OE_OUT(sdo_oe),
      .CONVERTING_OUT(conv), .NAP_OUT(nap), .SLEEP_OUT(sleep));
   sarpm_host u_sarpm_host (.lvds_in(lvds), .sdo_in(sdo_p), .cnv_n_out(cnv_n),
      .sck_p_out(sck_p), .sck_n_out(sck_n));
   task automatic chk(input string what, input logic [14:0] exp, input logic [14:0] got);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // power state as {sleep, nap}
   task automatic st(input logic [1:0] e);
      chk("power state", {13'h0, e}, {13'h0, sleep, nap});
   endtask
   task automatic t_read(input logic mode, input logic [14:0] v);
      logic [14:0] w;
      lvds = mode;
      result = v;
      #200 u_sarpm_host.read_word(w);
      chk("word", v, w);
      chk("neg drive", {14'h0, mode}, {14'h0, sdo_oe});
      st(2'b00);
      // the last fall shifts the word out; only zeros follow
      #200;
      chk("tail bit", 15'h0, {14'h0, sdo_p});
      if (mode)
         chk("neg data", 15'h1, {14'h0, sdo_n});
   endtask
   // pulses alone walk operational, nap, nap, sleep, operational
   task automatic t_cycle(input logic mode);
      logic [14:0] w;
      logic [1:0]  e;
      lvds = mode;
      #200 u_sarpm_host.read_word(w);
      for (int k = 1; k <= 10; k++)
      begin
         u_sarpm_host.pulse();
         e = (k % 5 == 2 || k % 5 == 3) ? 2'b01 : (k % 5 == 4) ? 2'b10 : 2'b00;
         st(e);
      end
      u_sarpm_host.read_word(w);
      u_sarpm_host.read_word(w);
      st(2'b00);
   endtask
   task automatic t_wake(input logic mode);
      logic [14:0] w;
      lvds = mode;
      #200 u_sarpm_host.read_word(w);
      repeat (2) u_sarpm_host.pulse();
      st(2'b01);
      u_sarpm_host.clock_once();
      st(2'b00);
      if (!mode)
      begin
         repeat (4) u_sarpm_host.pulse();
         st(2'b10);
         u_sarpm_host.clock_once();
         st(2'b00);
         #WAKE_NS;
      end
      else
      begin
         // lvds keeps sleep on a clock rise; only the fifth idle pulse wakes it
         repeat (4) u_sarpm_host.pulse();
         st(2'b10);
         u_sarpm_host.clock_once();
         st(2'b10);
         repeat (5) u_sarpm_host.pulse();
         st(2'b00);
         #WAKE_NS;
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ****
   // clock, sequence and watchdog
   // ****
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial
   begin
      rst = 1'b1;
      lvds = 1'b0;
      result = 15'h0;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      t_read(1'b0, 15'h6b59);
      t_read(1'b0, 15'h1ca6);
      t_read(1'b1, 15'h2c35);
      t_read(1'b1, 15'h5ac3);
      t_cycle(1'b0);
      t_cycle(1'b1);
      t_wake(1'b0);
      t_wake(1'b1);
      final_report();
   end
   // whole run needs about 116 us
   initial
   begin
      #400000 bad_count++;
      final_report();
   end
endmodule // test_sarpm_top
`default_nettype wire
